// [verilog/cif_pkg.sv]
// Shared constants for the converter interrupt flag block
package cif_pkg;
   // Register byte offsets on the internal register port
   localparam logic [7:0] CIF_OFS_TOP = 8'h18;
   localparam logic [7:0] CIF_OFS_REG01 = 8'h19;
   localparam logic [7:0] CIF_OFS_REG23 = 8'h1a;
   localparam logic [7:0] CIF_OFS_THERM = 8'h1b;
   // Reset value shared by all four registers
   localparam logic [7:0] CIF_RST_VAL = 8'h00;
   localparam int CIF_DW = 8;
   // Top register field positions
   localparam int CIF_B_SUM3 = 7;
   localparam int CIF_B_SUM0 = 4;
   localparam int CIF_B_TSD = 3;
   localparam int CIF_B_TWARN = 2;
   localparam int CIF_B_RSTREG = 1;
   localparam int CIF_B_LOAD = 0;
   // Regulator 0/1 register field positions
   localparam int CIF_B_R1_ILIM = 4;
   localparam int CIF_B_R0_PG = 2;
   localparam int CIF_B_R0_SC = 1;
   localparam int CIF_B_R0_ILIM = 0;
   // Regulator 2/3 register field positions
   localparam int CIF_B_R3_ILIM = 4;
   localparam int CIF_B_R2_ILIM = 0;
   // Thermal live status positions
   localparam int CIF_B_TSD_LIVE = 3;
   localparam int CIF_B_TWARN_LIVE = 2;
   // Writable flag masks, reserved bits excluded
   localparam logic [7:0] CIF_TOP_W1C = 8'h0f;
   localparam logic [7:0] CIF_REG01_W1C = 8'h17;
   localparam logic [7:0] CIF_REG23_W1C = 8'h11;
   // Synchronised event inputs
   localparam int CIF_EV_TSD = 0;
   localparam int CIF_EV_TWARN = 1;
   localparam int CIF_EV_SUPLOW = 2;
   localparam int CIF_EV_RSTPIN = 3;
   localparam int CIF_EV_PG = 4;
   localparam int CIF_EV_ABOVE = 5;
   localparam int CIF_EV_ILIM0 = 6;
   localparam int CIF_NUM_EV = 10;
   localparam int CIF_NUM_REG = 4;
   // Start-up short window
   localparam int CIF_CLK_MHZ = 50;
   localparam int CIF_SHORT_WIN_US = 1000;
   localparam int CIF_SHORT_WIN_CYC = CIF_SHORT_WIN_US * CIF_CLK_MHZ;
endpackage

// [verilog/cif_evt_if.sv]
// Carrier of raw and synchronised analog event levels
`timescale 1ns/1ps
interface cif_evt_if #(parameter int N = cif_pkg::CIF_NUM_EV);
   logic [N-1:0] raw; // Asynchronous comparator levels
   logic [N-1:0] level; // Levels after two flops
   logic [N-1:0] rise; // One-cycle rising edge pulses
   modport sync_side (input raw, output level, rise);
   modport user_side (output raw, input level, rise);
endinterface

// [verilog/cif_event_sync.sv]
// Two-flop synchronisers with rising edge detection per event
`timescale 1ns/1ps
module cif_event_sync #(
   parameter int N = cif_pkg::CIF_NUM_EV
) (
   // Clock and control
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Event carrier
   cif_evt_if.sync_side evt
);
   import cif_pkg::*;
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_ev
         logic s1; // First stage, read by s2 only
         logic s2; // Settled level
         logic s3; // Previous settled level
         // Synchroniser chain, frozen with the clock enable
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end
            else if (clk_en)
            begin
               s1 <= evt.raw[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         // Edge only looks at settled stages
         assign evt.level[i] = s2;
         assign evt.rise[i] = s2 & ~s3;
      end
   endgenerate
endmodule // cif_event_sync

// [verilog/cif_flags.sv]
// Interrupt flag registers of the four-phase step-down converter
`timescale 1ns/1ps
module cif_flags #(
   parameter int SHORT_WIN_CYC = cif_pkg::CIF_SHORT_WIN_CYC
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // Register port from the serial interface engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [cif_pkg::CIF_DW-1:0] reg_wdata,
   input wire logic reg_rd,
   output logic [cif_pkg::CIF_DW-1:0] reg_rdata,
   // Asynchronous analog comparator levels
   input wire logic thermal_shutdown_cmp,
   input wire logic thermal_warning_cmp,
   input wire logic analog_supply_low,
   input wire logic chip_reset_pin,
   input wire logic regulator0_pg_cmp,
   input wire logic regulator0_above_short_cmp,
   input wire logic [cif_pkg::CIF_NUM_REG-1:0] current_limit_cmp,
   // Same-clock requests and masks
   input wire logic load_measure_done,
   input wire logic software_reset_request,
   input wire logic regulator_enable_request,
   input wire logic [cif_pkg::CIF_DW-1:0] top_mask,
   input wire logic [cif_pkg::CIF_DW-1:0] regulator01_mask,
   input wire logic [cif_pkg::CIF_DW-1:0] regulator23_mask,
   // Results
   output logic regulator_enable,
   output logic register_restore,
   output logic host_interrupt
);
   import cif_pkg::*;

   // Event synchroniser
   cif_evt_if #(.N(CIF_NUM_EV)) evt ();
   assign evt.raw = {current_limit_cmp, regulator0_above_short_cmp, regulator0_pg_cmp,
                     chip_reset_pin, analog_supply_low, thermal_warning_cmp,
                     thermal_shutdown_cmp};
   cif_event_sync #(.N(CIF_NUM_EV)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .evt(evt)
   );

   localparam int TW = $clog2(SHORT_WIN_CYC + 1);
   localparam logic [TW-1:0] WIN_END = TW'(SHORT_WIN_CYC);

   logic [CIF_DW-1:0] top_flags; // Latched low nibble of top register
   logic [CIF_DW-1:0] reg01_flags; // Regulator 0/1 flags
   logic [CIF_DW-1:0] reg23_flags; // Regulator 2/3 flags
   logic [CIF_NUM_REG-1:0] summary; // Per-regulator pending
   logic [CIF_DW-1:0] top_view; // Top register as read
   logic [CIF_DW-1:0] therm_view; // Thermal live as read
   logic [CIF_DW-1:0] top_set; // Set terms, top
   logic [CIF_DW-1:0] reg01_set; // Set terms, regulator 0/1
   logic [CIF_DW-1:0] reg23_set; // Set terms, regulator 2/3
   logic [CIF_DW-1:0] top_clr; // Clear terms, top
   logic [CIF_DW-1:0] reg01_clr; // Clear terms, regulator 0/1
   logic [CIF_DW-1:0] reg23_clr; // Clear terms, regulator 2/3
   logic reset_event; // Any of the three reset causes
   logic reached; // Output passed short threshold since enable
   logic [TW-1:0] win_cnt; // Start-up window counter
   logic short_now; // Short condition this cycle

   // Summary bits derive from group contents, never stored
   assign summary[0] = |reg01_flags[CIF_B_R0_PG:CIF_B_R0_ILIM];
   assign summary[1] = reg01_flags[CIF_B_R1_ILIM];
   assign summary[2] = reg23_flags[CIF_B_R2_ILIM];
   assign summary[3] = reg23_flags[CIF_B_R3_ILIM];
   assign top_view = {summary, top_flags[CIF_B_TSD:CIF_B_LOAD]};

   // Live comparator state, unlatched
   always_comb
   begin
      therm_view = CIF_RST_VAL;
      therm_view[CIF_B_TSD_LIVE] = evt.level[CIF_EV_TSD];
      therm_view[CIF_B_TWARN_LIVE] = evt.level[CIF_EV_TWARN];
   end

   // Pin rise, supply drop or software request all restart the device
   assign reset_event = evt.rise[CIF_EV_RSTPIN] | evt.rise[CIF_EV_SUPLOW]
                        | software_reset_request;

   // Short: drop after reaching, or never reaching within the window
   assign short_now = regulator_enable & ~evt.level[CIF_EV_ABOVE]
                      & (reached | (win_cnt == WIN_END));

   // Event set terms
   always_comb
   begin
      top_set = CIF_RST_VAL;
      reg01_set = CIF_RST_VAL;
      reg23_set = CIF_RST_VAL;
      top_set[CIF_B_TSD] = evt.rise[CIF_EV_TSD];
      top_set[CIF_B_TWARN] = evt.rise[CIF_EV_TWARN];
      top_set[CIF_B_LOAD] = load_measure_done;
      reg01_set[CIF_B_R0_PG] = evt.rise[CIF_EV_PG];
      reg01_set[CIF_B_R0_SC] = short_now;
      // Level sets: flag records that the limit has been active
      reg01_set[CIF_B_R0_ILIM] = evt.level[CIF_EV_ILIM0];
      reg01_set[CIF_B_R1_ILIM] = evt.level[CIF_EV_ILIM0 + 1];
      reg23_set[CIF_B_R2_ILIM] = evt.level[CIF_EV_ILIM0 + 2];
      reg23_set[CIF_B_R3_ILIM] = evt.level[CIF_EV_ILIM0 + 3];
   end

   // Write-one clears; zeros and reserved bits have no effect
   always_comb
   begin
      top_clr = CIF_RST_VAL;
      reg01_clr = CIF_RST_VAL;
      reg23_clr = CIF_RST_VAL;
      if (reg_wr && reg_addr == CIF_OFS_TOP)
      begin
         top_clr = reg_wdata & CIF_TOP_W1C;
      end
      if (reg_wr && reg_addr == CIF_OFS_REG01)
      begin
         reg01_clr = reg_wdata & CIF_REG01_W1C;
      end
      if (reg_wr && reg_addr == CIF_OFS_REG23)
      begin
         reg23_clr = reg_wdata & CIF_REG23_W1C;
      end
   end

   // Top flags; reset event wipes the rest and leaves its own flag
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         top_flags <= CIF_RST_VAL;
      end
      else if (clk_en)
      begin
         if (reset_event)
         begin
            top_flags <= CIF_RST_VAL;
            top_flags[CIF_B_RSTREG] <= 1'b1;
         end
         else
         begin
            // Set applied after clear so a same-cycle event survives
            top_flags <= (top_flags & ~top_clr) | top_set;
         end
      end
   end

   // Regulator flag registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         reg01_flags <= CIF_RST_VAL;
         reg23_flags <= CIF_RST_VAL;
      end
      else if (clk_en)
      begin
         if (reset_event)
         begin
            // Defaults restored along with the other registers
            reg01_flags <= CIF_RST_VAL;
            reg23_flags <= CIF_RST_VAL;
         end
         else
         begin
            reg01_flags <= (reg01_flags & ~reg01_clr) | reg01_set;
            reg23_flags <= (reg23_flags & ~reg23_clr) | reg23_set;
         end
      end
   end

   // Regulator enable gate; shutdown latch overrides the request
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         regulator_enable <= 1'b0;
      end
      else if (clk_en)
      begin
         if (reset_event || top_set[CIF_B_TSD] || top_flags[CIF_B_TSD])
         begin
            regulator_enable <= 1'b0;
         end
         else
         begin
            regulator_enable <= regulator_enable_request;
         end
      end
   end

   // Start-up window counter and threshold-reached memory
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         win_cnt <= '0;
         reached <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!regulator_enable)
         begin
            // Re-armed on every enable
            win_cnt <= '0;
            reached <= 1'b0;
         end
         else
         begin
            if (win_cnt != WIN_END)
            begin
               win_cnt <= win_cnt + TW'(1);
            end
            if (evt.level[CIF_EV_ABOVE])
            begin
               reached <= 1'b1;
            end
         end
      end
   end

   // Restore strobe to the rest of the register file, one cycle
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         register_restore <= 1'b0;
      end
      else if (clk_en)
      begin
         register_restore <= reset_event;
      end
   end

   // Read data registered; unmapped offsets read zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         reg_rdata <= CIF_RST_VAL;
      end
      else if (clk_en && reg_rd)
      begin
         unique case (reg_addr)
            CIF_OFS_TOP: reg_rdata <= top_view;
            CIF_OFS_REG01: reg_rdata <= reg01_flags;
            CIF_OFS_REG23: reg_rdata <= reg23_flags;
            CIF_OFS_THERM: reg_rdata <= therm_view;
            default: reg_rdata <= CIF_RST_VAL;
         endcase
      end
   end

   // Mask gates only the interrupt line, flags latch regardless
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         host_interrupt <= 1'b0;
      end
      else if (clk_en)
      begin
         host_interrupt <= |(top_flags & CIF_TOP_W1C & ~top_mask)
                           | |(reg01_flags & ~regulator01_mask)
                           | |(reg23_flags & ~regulator23_mask);
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_summary_read: assert property (reg_rd && clk_en && reg_addr == CIF_OFS_TOP
      |=> reg_rdata[CIF_B_SUM3:CIF_B_SUM0] == {$past(reg23_flags[CIF_B_R3_ILIM]),
          $past(reg23_flags[CIF_B_R2_ILIM]), $past(reg01_flags[CIF_B_R1_ILIM]),
          $past(|reg01_flags[CIF_B_R0_PG:CIF_B_R0_ILIM])})
      else $error("summary bits wrong");
   a_tsd_latch: assert property (clk_en && evt.rise[CIF_EV_TSD] && !reset_event
      |=> top_flags[CIF_B_TSD])
      else $error("shutdown flag not latched");
   a_tsd_blocks_en: assert property (top_flags[CIF_B_TSD] |-> ##1 !regulator_enable)
      else $error("regulator enabled during shutdown");
   a_warn_latch: assert property (clk_en && evt.rise[CIF_EV_TWARN] && !reset_event
      |=> top_flags[CIF_B_TWARN])
      else $error("warning flag not latched");
   a_reset_seq: assert property (clk_en && reset_event |=> top_flags[CIF_B_RSTREG]
      && register_restore && !regulator_enable && reg01_flags == CIF_RST_VAL)
      else $error("reset sequence wrong");
   a_load_latch: assert property (clk_en && load_measure_done && !reset_event
      |=> top_flags[CIF_B_LOAD])
      else $error("load ready not latched");
   a_short_drop: assert property (clk_en && regulator_enable && reached
      && !evt.level[CIF_EV_ABOVE] && !reset_event |=> reg01_flags[CIF_B_R0_SC])
      else $error("short flag missed");
   a_pg_latch: assert property (clk_en && evt.rise[CIF_EV_PG] && !reset_event
      |=> reg01_flags[CIF_B_R0_PG])
      else $error("power good flag missed");
   a_ilim_latch: assert property (clk_en && evt.level[CIF_EV_ILIM0 + 3] && !reset_event
      |=> reg23_flags[CIF_B_R3_ILIM])
      else $error("current limit flag missed");
   a_live_read: assert property (clk_en && reg_rd && reg_addr == CIF_OFS_THERM
      |=> reg_rdata[CIF_B_TSD_LIVE] == $past(evt.level[CIF_EV_TSD]))
      else $error("live thermal read wrong");
   a_mask_no_block: assert property (clk_en && top_mask[CIF_B_LOAD] && load_measure_done
      && !reset_event |=> top_flags[CIF_B_LOAD])
      else $error("mask blocked flag");
   a_zero_write: assert property (clk_en && reg_wr && reg_addr == CIF_OFS_REG23
      && reg_wdata == CIF_RST_VAL && !reset_event
      |=> (reg23_flags & $past(reg23_flags)) == $past(reg23_flags))
      else $error("zero write cleared flag");
   a_irq_follow: assert property (clk_en && |(reg01_flags & ~regulator01_mask)
      |=> host_interrupt)
      else $error("interrupt missing");

   c_tsd: cover property (evt.rise[CIF_EV_TSD] ##[1:20] !regulator_enable);
   c_short_timeout: cover property (regulator_enable && win_cnt == WIN_END
      && !reached ##1 reg01_flags[CIF_B_R0_SC]);
   c_clear_race: cover property (reg_wr && reg_addr == CIF_OFS_TOP && load_measure_done);
   c_irq: cover property ($rose(host_interrupt) ##[1:50] !host_interrupt);
endmodule // cif_flags

// [tb/cif_host_model.sv]
// Host side driver of the internal register port
`timescale 1ns/1ps
module cif_host_model (
   // Clock
   input wire logic sys_clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [cif_pkg::CIF_DW-1:0] reg_wdata,
   output logic reg_rd,
   input wire logic [cif_pkg::CIF_DW-1:0] reg_rdata
);
   import cif_pkg::*;
   // Idle port at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // One-cycle write; idle lines then scrambled so stale data never helps
   task automatic wr(input logic [7:0] a, input logic [CIF_DW-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // Read; data lands on the taking edge and is sampled one cycle later
   task automatic rd(input logic [7:0] a, output logic [CIF_DW-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge sys_clk);
      #1 d = reg_rdata;
   endtask
endmodule // cif_host_model

// [tb/tb_top.sv]
// Self-checking bench for the converter interrupt flag block
`timescale 1ns/1ps
module tb_top;
   import cif_pkg::*;
   localparam int WIN = 20; // Short start-up window keeps the run brief
   // Design ports
   logic sys_clk, rst, clk_en, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic thermal_shutdown_cmp, thermal_warning_cmp, analog_supply_low, chip_reset_pin;
   logic regulator0_pg_cmp, regulator0_above_short_cmp, load_measure_done;
   logic software_reset_request, regulator_enable_request;
   logic [3:0] current_limit_cmp;
   logic [7:0] top_mask, regulator01_mask, regulator23_mask;
   logic regulator_enable, register_restore, host_interrupt;
   // Bench state
   int error_cnt, check_count, cyc;
   logic [31:0] seed;
   logic [7:0] rv, e01, e23;
   logic [3:0] e_t; // Expected top flags 3..0
   cif_flags #(.SHORT_WIN_CYC(WIN)) cif_flags_i (.sys_clk, .rst, .clk_en, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .thermal_shutdown_cmp,
      .thermal_warning_cmp, .analog_supply_low, .chip_reset_pin, .regulator0_pg_cmp,
      .regulator0_above_short_cmp, .current_limit_cmp, .load_measure_done,
      .software_reset_request, .regulator_enable_request, .top_mask, .regulator01_mask,
      .regulator23_mask, .regulator_enable, .register_restore, .host_interrupt);
   cif_host_model cif_host_model_i (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata);
   // Clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         $display("unexpected timeout expected finish seen hang");
         give_verdict();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Summary bits follow the per-regulator groups
   function automatic logic [7:0] top_exp();
      return {e23[4], e23[0], e01[4], |e01[2:0], e_t};
   endfunction
   // Masks gate only the interrupt
   function automatic logic irq_exp();
      return |(e_t & ~top_mask[3:0]) | |(e01 & ~regulator01_mask) |
         |(e23 & ~regulator23_mask);
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (e !== g)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      cif_host_model_i.rd(a, rv);
      chk($sformatf("register %h", a), e, rv);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // All flag registers and the interrupt line against the model
   task automatic chk_all();
      rdc(CIF_OFS_TOP, top_exp());
      rdc(CIF_OFS_REG01, e01);
      rdc(CIF_OFS_REG23, e23);
      chk("host_interrupt", {7'h00, irq_exp()}, {7'h00, host_interrupt});
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      {rst, clk_en, regulator0_above_short_cmp} = 3'h7;
      {thermal_shutdown_cmp, thermal_warning_cmp, analog_supply_low, chip_reset_pin} = 4'h0;
      {regulator0_pg_cmp, load_measure_done, software_reset_request} = 3'h0;
      regulator_enable_request = 1'b0;
      current_limit_cmp = 4'h0;
      {top_mask, regulator01_mask, regulator23_mask} = 24'h00_0000;
      {error_cnt, check_count, cyc} = '0;
      seed = 32'h0000_0054;
      {e_t, e01, e23} = '0;
      wt(8);
      rst <= 1'b0;
      chk_all();
      cif_host_model_i.wr(CIF_OFS_THERM, 8'hff);
      rdc(CIF_OFS_THERM, 8'h00);
      rdc(8'h42, 8'h00);
      // Frozen block ignores a measurement pulse
      @(posedge sys_clk);
      clk_en <= 1'b0;
      load_measure_done <= 1'b1;
      wt(3);
      {clk_en, load_measure_done} <= 2'h2;
      chk_all();
      $display("test reset values done");
      // Shutdown kills a running regulator and blocks it
      @(posedge sys_clk);
      regulator_enable_request <= 1'b1;
      wt(4);
      thermal_shutdown_cmp <= 1'b1;
      wt(6);
      e_t[3] = 1'b1;
      chk("regulator_enable", 8'h00, {7'h00, regulator_enable});
      chk_all();
      rdc(CIF_OFS_THERM, 8'h08);
      @(posedge sys_clk);
      thermal_shutdown_cmp <= 1'b0;
      cif_host_model_i.wr(CIF_OFS_TOP, 8'h00);
      chk_all();
      chk("regulator_enable", 8'h00, {7'h00, regulator_enable});
      cif_host_model_i.wr(CIF_OFS_TOP, 8'h08);
      e_t[3] = 1'b0;
      chk_all();
      $display("test shutdown done");
      // Masked warning still latches
      @(posedge sys_clk);
      regulator_enable_request <= 1'b0;
      top_mask <= 8'h04;
      thermal_warning_cmp <= 1'b1;
      wt(6);
      e_t[2] = 1'b1;
      chk_all();
      rdc(CIF_OFS_THERM, 8'h04);
      @(posedge sys_clk);
      thermal_warning_cmp <= 1'b0;
      wt(5);
      rdc(CIF_OFS_THERM, 8'h00);
      chk_all();
      cif_host_model_i.wr(CIF_OFS_TOP, 8'h04);
      e_t[2] = 1'b0;
      chk_all();
      $display("test warning done");
      // Measurement ready, then a clear colliding with a new result
      for (int k = 0; k < 2; k++)
      begin
         fork
            if (k == 1) cif_host_model_i.wr(CIF_OFS_TOP, 8'h01);
            begin
               @(posedge sys_clk);
               load_measure_done <= 1'b1;
               top_mask[0] <= (k == 1);
               @(posedge sys_clk);
               load_measure_done <= 1'b0;
            end
         join
         e_t[0] = 1'b1;
         chk_all();
      end
      cif_host_model_i.wr(CIF_OFS_TOP, 8'h01);
      e_t[0] = 1'b0;
      chk_all();
      $display("test measurement done");
      // Random current limits, masks and clears
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         @(posedge sys_clk);
         current_limit_cmp <= seed[3:0];
         regulator01_mask <= seed[15:8];
         regulator23_mask <= seed[23:16];
         top_mask <= {4'h0, seed[27:24]};
         e01 |= {3'h0, seed[1], 3'h0, seed[0]};
         e23 |= {3'h0, seed[3], 3'h0, seed[2]};
         wt(6);
         current_limit_cmp <= 4'h0;
         wt(4);
         chk_all();
         cif_host_model_i.wr(CIF_OFS_REG23, 8'h00);
         seed = xs(seed);
         cif_host_model_i.wr(CIF_OFS_REG01, seed[7:0]);
         cif_host_model_i.wr(CIF_OFS_REG23, seed[15:8]);
         cif_host_model_i.wr(CIF_OFS_TOP, seed[23:16]);
         e01 &= ~(seed[7:0] & CIF_REG01_W1C);
         e23 &= ~(seed[15:8] & CIF_REG23_W1C);
         chk_all();
      end
      cif_host_model_i.wr(CIF_OFS_REG01, 8'hff);
      cif_host_model_i.wr(CIF_OFS_REG23, 8'hff);
      {e01, e23} = 16'h0000;
      chk_all();
      $display("test current limit done");
      // Start-up never reaching threshold, then collapse in operation
      @(posedge sys_clk);
      {top_mask, regulator01_mask, regulator23_mask} <= 24'h00_0000;
      regulator0_above_short_cmp <= 1'b0;
      wt(4);
      regulator_enable_request <= 1'b1;
      regulator0_pg_cmp <= 1'b1;
      wt(WIN + 10);
      e01 = 8'h06;
      chk_all();
      @(posedge sys_clk);
      regulator0_above_short_cmp <= 1'b1;
      wt(6);
      cif_host_model_i.wr(CIF_OFS_REG01, 8'h06);
      e01 = 8'h00;
      chk_all();
      @(posedge sys_clk);
      regulator0_above_short_cmp <= 1'b0;
      wt(6);
      e01 = 8'h02;
      chk_all();
      @(posedge sys_clk);
      regulator_enable_request <= 1'b0;
      regulator0_above_short_cmp <= 1'b1;
      wt(4);
      cif_host_model_i.wr(CIF_OFS_REG01, 8'h02);
      e01 = 8'h00;
      chk_all();
      $display("test short and power good done");
      // Software reset wipes other flags and restarts
      @(posedge sys_clk);
      load_measure_done <= 1'b1;
      regulator_enable_request <= 1'b1;
      @(posedge sys_clk);
      load_measure_done <= 1'b0;
      wt(4);
      software_reset_request <= 1'b1;
      @(posedge sys_clk);
      software_reset_request <= 1'b0;
      regulator_enable_request <= 1'b0;
      #1 chk("register_restore", 8'h01, {7'h00, register_restore});
      chk("regulator_enable", 8'h00, {7'h00, regulator_enable});
      @(posedge sys_clk);
      #1 chk("register_restore", 8'h00, {7'h00, register_restore});
      e_t = 4'h2;
      chk_all();
      for (int k = 0; k < 3; k++)
      begin
         cif_host_model_i.wr(CIF_OFS_TOP, 8'h02);
         e_t = 4'h0;
         chk_all();
         if (k == 2) break;
         @(posedge sys_clk);
         {analog_supply_low, chip_reset_pin} <= (k == 0) ? 2'h1 : 2'h2;
         wt(6);
         {analog_supply_low, chip_reset_pin} <= 2'h0;
         e_t = 4'h2;
         chk_all();
      end
      $display("test reset events done");
      give_verdict();
   end
endmodule // tb_top
